/* File: core/emt_map.svh */
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Included by the controller by bare name
// Notes: Offsets are byte addresses on the plain 8-bit register port
`ifndef EMT_MAP_SVH
`define EMT_MAP_SVH

// Register offsets
`define EMT_OFF_TIMING 8'haa
`define EMT_OFF_CONFIG 8'hab
`define EMT_OFF_BANK 8'hac
`define EMT_OFF_STATUS 8'had

// Timing register fields
`define EMT_SETUP_MSB 7
`define EMT_SETUP_LSB 6
`define EMT_WIDTH_MSB 5
`define EMT_WIDTH_LSB 2
`define EMT_HOLD_MSB 1
`define EMT_HOLD_LSB 0

// Config register fields
`define EMT_MODE_MSB 4
`define EMT_MODE_LSB 2
`define EMT_MUX_BIT 4
`define EMT_ALE_MSB 1
`define EMT_ALE_LSB 0

// Reset values
`define EMT_RST_TIMING 8'hff
`define EMT_RST_CONFIG 8'h03
`define EMT_RST_BANK 8'h00

// Length of the fixed tail closing every off-chip move, in core clock cycles
`define EMT_TAIL_CYCLES 4'h4

`endif

/* File: core/emt_pkg.sv */
// Purpose: Types shared by the external memory timing controller
// Assumes: Constants live in emt_map.svh
// Notes: States are Gray coded along the usual path
package emt_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    EMT_IDLE   = 3'h0,
    EMT_ALE_HI = 3'h1,
    EMT_ALE_LO = 3'h3,
    EMT_SETUP  = 3'h2,
    EMT_STROBE = 3'h6,
    EMT_HOLD   = 3'h7,
    EMT_TAIL   = 3'h5
  } emt_state_t;

endpackage

/* File: core/emt_ctrl.sv */
// Purpose: External memory interface timing and mode sequencing
// Assumes: One core clock, synchronous active-high reset, off-chip moves only
// Notes: Read data pins pass a three-flop synchroniser before capture
//
// What this block does
// - Modes 101/110/111 use non-multiplexed 16-bit sequence
// - Mode 110 8-bit drives upper byte from bank
// - Modes 001/010/011 use multiplexed sequence with latch
// - Modes 001/011 8-bit leave upper byte undriven
// - Multiplexed 8-bit bank select uses bank upper byte
// - Non-mux 8-bit no-bank: low index, upper undriven
// - Reset loads maximum setup, width, hold values
// - Every external move lasts parameters plus five cycles
// - Multiplexed adds at least two latch cycles
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "emt_map.svh"

module emt_ctrl (
  input wire logic core_clk, // 125 MHz core clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [7:0] reg_rdata_q, // Read data, cycle after strobe
  input wire logic mv_req, // External data move request pulse
  input wire logic mv_write, // Move is a write
  input wire logic mv_wide, // Move is 16-bit addressed
  input wire logic [15:0] mv_addr, // Move address, low byte is index for 8-bit
  input wire logic [7:0] mv_wdata, // Write data
  output logic mv_busy_q, // Move in progress
  output logic mv_done_q, // Move finished pulse
  output logic [7:0] mv_rdata_q, // Captured read data
  output logic [7:0] addr_hi_q, // Upper address pins
  output logic addr_hi_oe_q, // Upper address drive enable
  output logic [7:0] addr_lo_q, // Lower address pins, non-multiplexed
  output logic addr_lo_oe_q, // Lower address drive enable
  output logic [7:0] ad_out_q, // Data or muxed address out
  output logic ad_oe_q, // Data pin drive enable
  input wire logic [7:0] ad_in, // Data pins in
  output logic ale_q, // Address latch enable, active high
  output logic rd_n_q, // Read strobe, active low
  output logic wr_n_q // Write strobe, active low
);

  // Non-zero low two bits of the memory-mode field mean external space is reachable
  function automatic logic mode_ext(input logic [2:0] m);
    mode_ext = (m[1:0] != 2'b00);
  endfunction

  // Bank register supplies upper byte for 8-bit moves in split-with-bank
  function automatic logic mode_bank(input logic [2:0] m);
    mode_bank = (m[1:0] == 2'b10);
  endfunction

  logic [7:0] timing_q; // Timing control register
  logic [7:0] config_q; // Mode and latch width
  logic [7:0] bank_q; // Bank register
  emt_pkg::emt_state_t state_q; // Sequencer state
  emt_pkg::emt_state_t state_d; // Next sequencer state
  logic [3:0] cnt_q; // Cycles left in current phase
  logic [3:0] cnt_d; // Next phase count
  logic write_q; // Latched direction
  logic wide_q; // Latched width
  logic [15:0] addr_q; // Latched address
  logic [7:0] wdata_q; // Latched write data
  logic [7:0] sync1_q; // Data pin sync stage one
  logic [7:0] sync2_q; // Data pin sync stage two
  logic [7:0] sync3_q; // Data pin sync stage three
  logic [2:0] rd_pipe_q; // Strobe timing marks read data; a 1-cycle strobe agrees as well
  logic [2:0] mode; // Mode configuration bits
  logic mux; // Multiplexed sequence selected
  logic take; // Request accepted this cycle
  logic miss; // Request in internal-only mode
  wire [15:0] cur_addr = take ? mv_addr : addr_q; // Address, valid in the take cycle too
  wire cur_write = take ? mv_write : write_q; // Direction, valid in the take cycle too
  wire rd_end = (state_q == emt_pkg::EMT_STROBE) && (cnt_q == 4'h0) && !write_q; // Read ends

  assign mode = config_q[`EMT_MODE_MSB:`EMT_MODE_LSB];
  assign mux = ~config_q[`EMT_MUX_BIT];
  assign take = mv_req & (state_q == emt_pkg::EMT_IDLE) & ~mv_busy_q;
  assign miss = take & ~mode_ext(mode);

  // Register writes; reset to maximum delays
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timing_q <= `EMT_RST_TIMING;
      config_q <= `EMT_RST_CONFIG;
      bank_q <= `EMT_RST_BANK;
    end else if (reg_wr) begin
      case (reg_addr)
        `EMT_OFF_TIMING: timing_q <= reg_wdata;
        `EMT_OFF_CONFIG: config_q <= {3'h0, reg_wdata[4:0]};
        `EMT_OFF_BANK: bank_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped reads return zero, data stands one cycle
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        `EMT_OFF_TIMING: reg_rdata_q <= timing_q;
        `EMT_OFF_CONFIG: reg_rdata_q <= config_q;
        `EMT_OFF_BANK: reg_rdata_q <= bank_q;
        `EMT_OFF_STATUS: reg_rdata_q <= {7'h00, mv_busy_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Latch the move so later request pins may change freely
  always_ff @(posedge core_clk) begin
    if (srst) begin
      write_q <= 1'b0;
      wide_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else if (take) begin
      write_q <= mv_write;
      wide_q <= mv_wide;
      addr_q <= mv_addr;
      wdata_q <= mv_wdata;
    end
  end

  // Phase sequencing; fields are read as each phase starts
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      emt_pkg::EMT_IDLE: begin
        if (take && !miss) begin
          if (mux) begin
            state_d = emt_pkg::EMT_ALE_HI;
            cnt_d = {2'b00, config_q[`EMT_ALE_MSB:`EMT_ALE_LSB]};
          end else if (timing_q[`EMT_SETUP_MSB:`EMT_SETUP_LSB] != 2'b00) begin
            state_d = emt_pkg::EMT_SETUP;
            cnt_d = {2'b00, timing_q[`EMT_SETUP_MSB:`EMT_SETUP_LSB]} - 4'h1;
          end else begin
            state_d = emt_pkg::EMT_STROBE;
            cnt_d = timing_q[`EMT_WIDTH_MSB:`EMT_WIDTH_LSB];
          end
        end
      end
      emt_pkg::EMT_ALE_HI: begin
        if (cnt_q == 4'h0) begin
          state_d = emt_pkg::EMT_ALE_LO;
          cnt_d = {2'b00, config_q[`EMT_ALE_MSB:`EMT_ALE_LSB]};
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      emt_pkg::EMT_ALE_LO: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (timing_q[`EMT_SETUP_MSB:`EMT_SETUP_LSB] != 2'b00) begin
          state_d = emt_pkg::EMT_SETUP;
          cnt_d = {2'b00, timing_q[`EMT_SETUP_MSB:`EMT_SETUP_LSB]} - 4'h1;
        end else begin
          state_d = emt_pkg::EMT_STROBE;
          cnt_d = timing_q[`EMT_WIDTH_MSB:`EMT_WIDTH_LSB];
        end
      end
      emt_pkg::EMT_SETUP: begin
        if (cnt_q == 4'h0) begin
          state_d = emt_pkg::EMT_STROBE;
          cnt_d = timing_q[`EMT_WIDTH_MSB:`EMT_WIDTH_LSB];
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      emt_pkg::EMT_STROBE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (timing_q[`EMT_HOLD_MSB:`EMT_HOLD_LSB] != 2'b00) begin
          state_d = emt_pkg::EMT_HOLD;
          cnt_d = {2'b00, timing_q[`EMT_HOLD_MSB:`EMT_HOLD_LSB]} - 4'h1;
        end else begin
          state_d = emt_pkg::EMT_TAIL;
          cnt_d = `EMT_TAIL_CYCLES - 4'h1;
        end
      end
      emt_pkg::EMT_HOLD: begin
        if (cnt_q == 4'h0) begin
          state_d = emt_pkg::EMT_TAIL;
          cnt_d = `EMT_TAIL_CYCLES - 4'h1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      emt_pkg::EMT_TAIL: begin
        if (cnt_q == 4'h0) begin
          state_d = emt_pkg::EMT_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = emt_pkg::EMT_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  // State and phase counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= emt_pkg::EMT_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Busy and done; internal-only requests finish at once with no bus cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mv_busy_q <= 1'b0;
      mv_done_q <= 1'b0;
    end else begin
      mv_busy_q <= (state_d != emt_pkg::EMT_IDLE);
      mv_done_q <= miss | ((state_q == emt_pkg::EMT_TAIL) && (cnt_q == 4'h0));
    end
  end

  // Three-flop synchroniser on data pins; read data taken from stage three
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
      rd_pipe_q <= 3'h0;
      mv_rdata_q <= 8'h00;
    end else begin
      sync1_q <= ad_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      rd_pipe_q <= {rd_pipe_q[1:0], rd_end};
      if (rd_pipe_q[2]) begin
        mv_rdata_q <= sync3_q; // Last strobe sample, three edges on, inside the tail
      end
    end
  end

  // Pin drive from next state so pins line up with the phase registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_hi_q <= 8'h00;
      addr_hi_oe_q <= 1'b0;
      addr_lo_q <= 8'h00;
      addr_lo_oe_q <= 1'b0;
      ad_out_q <= 8'h00;
      ad_oe_q <= 1'b0;
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      ale_q <= (state_d == emt_pkg::EMT_ALE_HI);
      rd_n_q <= ~((state_d == emt_pkg::EMT_STROBE) & ~cur_write);
      wr_n_q <= ~((state_d == emt_pkg::EMT_STROBE) & cur_write);
      if (state_d == emt_pkg::EMT_IDLE || state_d == emt_pkg::EMT_TAIL) begin
        // Released outside the access window
        addr_hi_oe_q <= 1'b0;
        addr_lo_oe_q <= 1'b0;
        ad_oe_q <= 1'b0;
      end else begin
        if (take ? mv_wide : wide_q) begin
          addr_hi_q <= cur_addr[15:8];
          addr_hi_oe_q <= 1'b1;
        end else if (mode_bank(mode)) begin
          addr_hi_q <= bank_q;
          addr_hi_oe_q <= 1'b1;
        end else begin
          // Upper pins left to the port latches
          addr_hi_oe_q <= 1'b0;
        end
        addr_lo_q <= cur_addr[7:0];
        addr_lo_oe_q <= ~mux;
        if (mux && (state_d == emt_pkg::EMT_ALE_HI || state_d == emt_pkg::EMT_ALE_LO)) begin
          ad_out_q <= cur_addr[7:0];
          ad_oe_q <= 1'b1;
        end else begin
          ad_out_q <= take ? mv_wdata : wdata_q;
          ad_oe_q <= cur_write;
        end
      end
    end
  end

endmodule

/* File: bench/emt_ctrl_chk.sv */
// Purpose: Port-level checks of the external memory timing controller
// Assumes: One core clock domain, bound onto emt_ctrl
// Notes: Released means both strobes high and no pin driven
`timescale 1ns/1ps
module emt_ctrl_chk (
  input wire logic core_clk, // Core clock
  input wire logic srst, // Sync reset
  input wire logic mv_req, // Move request
  input wire logic mv_busy_q, // Move busy
  input wire logic mv_done_q, // Move done pulse
  input wire logic addr_hi_oe_q, // Upper address enable
  input wire logic addr_lo_oe_q, // Lower address enable
  input wire logic ad_oe_q, // Data pin enable
  input wire logic ale_q, // Latch enable
  input wire logic rd_n_q, // Read strobe
  input wire logic wr_n_q // Write strobe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Whole bus let go, as in the fixed tail
  wire rel = rd_n_q && wr_n_q && !ad_oe_q && !addr_hi_oe_q && !addr_lo_oe_q;
  strobe_excl_a: assert property (rd_n_q || wr_n_q)
    else $error("both strobes low");
  take_start_a: assert property (mv_req && !mv_busy_q && !mv_done_q |=> mv_busy_q || mv_done_q)
    else $error("idle request not taken");
  min_move_a: assert property ($rose(mv_busy_q) |-> mv_busy_q [*5])
    else $error("move shorter than five cycles");
  mux_min_a: assert property ($rose(ale_q) |-> mv_busy_q [*7])
    else $error("multiplexed move shorter than seven cycles");
  move_bound_a: assert property ($rose(mv_busy_q) |-> ##[1:40] mv_done_q)
    else $error("move never finished");
  tail_idle_a: assert property (mv_done_q |-> rel && $past(rel) && $past(rel, 2) && $past(rel, 3))
    else $error("bus not released in tail");
  lo_not_mux_a: assert property (ale_q |-> !addr_lo_oe_q)
    else $error("lower address pins driven in multiplexed move");
  write_data_a: assert property (!wr_n_q |-> ad_oe_q)
    else $error("write strobe without data driven");
  read_free_a: assert property (!rd_n_q |-> !ad_oe_q)
    else $error("data pins driven during read");
endmodule
bind emt_ctrl emt_ctrl_chk u_emt_ctrl_chk (.core_clk, .srst, .mv_req, .mv_busy_q, .mv_done_q,
  .addr_hi_oe_q, .addr_lo_oe_q, .ad_oe_q, .ale_q, .rd_n_q, .wr_n_q);

/* File: bench/emt_sram.sv */
// Purpose: Asynchronous SRAM with address latch on the far side of the pins
// Assumes: Undriven upper pins read as port latches holding zero
// Notes: Released data bus shows the inverse of the last value read
`timescale 1ns/1ps
module emt_sram (
  input wire logic core_clk, // Core clock
  input wire logic mux, // Multiplexed wiring
  input wire logic [7:0] addr_hi_q, // Upper address pins
  input wire logic addr_hi_oe_q, // Upper address enable
  input wire logic [7:0] addr_lo_q, // Lower address pins
  input wire logic [7:0] ad_out_q, // Data or address out
  input wire logic ad_oe_q, // Data enable
  input wire logic ale_q, // Latch enable
  input wire logic rd_n_q, // Read strobe
  input wire logic wr_n_q, // Write strobe
  output logic [7:0] ad_in // Data back to the block
);
  logic [7:0] mem [0:65535]; // Storage
  logic [7:0] lat_q = 8'h00; // Address latch
  logic [7:0] last_q = 8'h00; // Last value driven
  wire [15:0] a = {addr_hi_oe_q ? addr_hi_q : 8'h00, mux ? lat_q : addr_lo_q}; // Effective address
  // Latch follows the bus while enabled; write lands while strobe is low
  always @(posedge core_clk) begin
    if (ale_q) lat_q <= ad_out_q;
    if (!wr_n_q && ad_oe_q) mem[a] <= ad_out_q;
    if (!rd_n_q) last_q <= mem[a];
  end
  // No hold beyond the strobe, so stale data cannot pass for good
  assign ad_in = !rd_n_q ? mem[a] : ~last_q;
endmodule

/* File: bench/emt_ctrl_tb.sv */
// Purpose: Self-checking bench for the external memory timing controller
// Assumes: Partner SRAM on the pins, registers over the plain port
// Notes: Move lengths come from the timing and config fields
`timescale 1ns/1ps
module emt_ctrl_tb;
  logic core_clk = 1'b0, srst = 1'b1; // Clock and reset
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q; // Register port
  logic reg_wr = 1'b0, reg_rd = 1'b0; // Register strobes
  logic mv_req = 1'b0, mv_write = 1'b0, mv_wide = 1'b0; // Move request
  logic [15:0] mv_addr = 16'h0000; // Move address
  logic [7:0] mv_wdata = 8'h00, mv_rdata_q, addr_hi_q, addr_lo_q, ad_out_q, ad_in; // Data
  logic mv_busy_q, mv_done_q, addr_hi_oe_q, addr_lo_oe_q, ad_oe_q, ale_q, rd_n_q, wr_n_q; // Pins
  logic [7:0] cfg = 8'h03; // Config mirror
  logic hi_seen; // Upper pins driven in this move
  int compares = 0, miscompares = 0; // Counters
  logic [7:0] tim [6] = '{8'h00, 8'h40, 8'hc0, 8'h3c, 8'h03, 8'hff}; // Timing cases
  logic [7:0] cfgs [6] = '{8'h14, 8'h18, 8'h1c, 8'h04, 8'h08, 8'h0f}; // Mode cases
  always #4 core_clk = ~core_clk;
  emt_ctrl u_emt_ctrl (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .mv_req, .mv_write, .mv_wide, .mv_addr, .mv_wdata, .mv_busy_q, .mv_done_q, .mv_rdata_q,
    .addr_hi_q, .addr_hi_oe_q, .addr_lo_q, .addr_lo_oe_q, .ad_out_q, .ad_oe_q, .ad_in, .ale_q,
    .rd_n_q, .wr_n_q);
  emt_sram u_emt_sram (.core_clk, .mux(!cfg[4]), .addr_hi_q, .addr_hi_oe_q, .addr_lo_q,
    .ad_out_q, .ad_oe_q, .ale_q, .rd_n_q, .wr_n_q, .ad_in);
  // Note any upper-byte drive during a move
  always @(posedge core_clk) if (addr_hi_oe_q === 1'b1) hi_seen = 1'b1;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_q}, {8'h00, exp});
  endtask
  // Internal-only mode finishes in one cycle; otherwise fields plus five, done one cycle later
  function automatic int nexp(input logic [7:0] c, input logic [7:0] t);
    if (c[3:2] == 2'b00) return 1;
    return (c[4] ? 0 : 2 * (int'(c[1:0]) + 1)) + int'(t[7:6]) + int'(t[5:2]) + int'(t[1:0]) + 6;
  endfunction
  // One move; checks length, upper drive and read data
  task automatic mv(input logic w, input logic wide, input logic [15:0] a, input logic [7:0] d,
                    input int n, input logic hi);
    int k;
    @(posedge core_clk);
    mv_req <= 1'b1;
    mv_write <= w;
    mv_wide <= wide;
    mv_addr <= a;
    mv_wdata <= d;
    @(posedge core_clk);
    mv_req <= 1'b0;
    hi_seen = 1'b0;
    k = 1;
    #1;
    while (mv_done_q !== 1'b1 && k < 60) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk(16'(k), 16'(n));
    chk({15'h0000, hi_seen}, {15'h0000, hi});
    if (!w) chk({8'h00, mv_rdata_q}, {8'h00, d});
  endtask
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'haa, 8'hff);
    rd(8'hb0, 8'h00);
    rd(8'hab, 8'h03);
    rd(8'had, 8'h00);
    mv(1'b1, 1'b1, 16'h0100, 8'h11, 1, 1'b0);
    $display("test reset and internal done");
    cfg = 8'h1c;
    wr(8'hab, cfg);
    foreach (tim[i]) begin
      wr(8'haa, tim[i]);
      rd(8'haa, tim[i]);
      mv(1'b1, 1'b1, {8'h40, tim[i]}, ~tim[i], nexp(cfg, tim[i]), 1'b1);
      mv(1'b0, 1'b1, {8'h40, tim[i]}, ~tim[i], nexp(cfg, tim[i]), 1'b1);
    end
    $display("test timing fields done");
    wr(8'haa, 8'h00);
    wr(8'hac, 8'h12);
    rd(8'hac, 8'h12);
    foreach (cfgs[i]) begin
      cfg = cfgs[i];
      wr(8'hab, cfg);
      mv(1'b1, 1'b0, {8'h55, 8'(8'h30 + i)}, 8'(8'ha0 + i), nexp(cfg, 8'h00),
         cfg[3:2] == 2'b10);
      mv(1'b0, 1'b1, {(cfg[3:2] == 2'b10) ? 8'h12 : 8'h00, 8'(8'h30 + i)}, 8'(8'ha0 + i),
         nexp(cfg, 8'h00), 1'b1);
    end
    $display("test modes done");
    end_of_test();
  end
endmodule
